/* File: design/cet_pkg.sv */
// Constants shared by the cascaded event/PWM timer: register map, field
// positions, reset values and prescaler select codes.
// Assumes a 32-bit APB register bus with one register per aligned word.
package cet_pkg;

  // Counter width of the chained pair, and width of one half
  localparam int CET_CNT_W  = 16;
  localparam int CET_BYTE_W = 8;
  localparam int CET_ADDR_W = 12;

  // Register byte offsets
  localparam logic [CET_ADDR_W-1:0] CET_OFS_CTRL   = 12'h000;
  localparam logic [CET_ADDR_W-1:0] CET_OFS_PER_LO = 12'h004;
  localparam logic [CET_ADDR_W-1:0] CET_OFS_PER_HI = 12'h008;
  localparam logic [CET_ADDR_W-1:0] CET_OFS_DUT_LO = 12'h00C;
  localparam logic [CET_ADDR_W-1:0] CET_OFS_DUT_HI = 12'h010;
  localparam logic [CET_ADDR_W-1:0] CET_OFS_COUNT  = 12'h014;
  localparam logic [CET_ADDR_W-1:0] CET_OFS_STAT   = 12'h018;

  // Field positions in the control register
  localparam int CET_CTRL_RUN  = 0;
  localparam int CET_CTRL_PWM  = 1;
  localparam int CET_CTRL_EXT  = 2;
  localparam int CET_CTRL_PRE0 = 4;
  localparam int CET_CTRL_FF   = 7;

  // Field positions in the status register
  localparam int CET_STAT_FLOP = 0;
  localparam int CET_STAT_IRQ  = 1;
  localparam int CET_STAT_OVR  = 2;

  // Reset values, counter step and counter maximum
  localparam logic [CET_BYTE_W-1:0] CET_CTRL_RST = 8'h00;
  localparam logic [CET_BYTE_W-1:0] CET_BYTE_RST = 8'h00;
  localparam logic [CET_CNT_W-1:0]  CET_CNT_RST  = 16'h0000;
  localparam logic [CET_CNT_W-1:0]  CET_CNT_ONE  = 16'h0001;
  localparam logic [CET_CNT_W-1:0]  CET_CNT_MAX  = 16'hFFFF;
  localparam logic                  CET_FLOP_RST = 1'b0;

  // Prescaler select codes and the masks of their divide ratios
  localparam int CET_PRE_W = 11;
  localparam logic [2:0] CET_PRE_D2048 = 3'h0;
  localparam logic [2:0] CET_PRE_D128  = 3'h1;
  localparam logic [2:0] CET_PRE_D32   = 3'h2;
  localparam logic [2:0] CET_PRE_D8    = 3'h3;
  localparam logic [2:0] CET_PRE_D2    = 3'h4;
  localparam logic [CET_PRE_W-1:0] CET_MSK_D2048 = 11'h7FF;
  localparam logic [CET_PRE_W-1:0] CET_MSK_D128  = 11'h07F;
  localparam logic [CET_PRE_W-1:0] CET_MSK_D32   = 11'h01F;
  localparam logic [CET_PRE_W-1:0] CET_MSK_D8    = 11'h007;
  localparam logic [CET_PRE_W-1:0] CET_MSK_D2    = 11'h001;
  localparam logic [CET_PRE_W-1:0] CET_MSK_D1    = 11'h000;

endpackage : cet_pkg

/* File: design/cet_edge_sync.sv */
// Two-stage synchroniser for the external count pin with falling-edge detect.
// Assumes the pin is asynchronous to clk and each level lasts two clocks or more.
`timescale 1ns/100ps
module cet_edge_sync
  import cet_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // Pin and detected edge
  input  wire logic pinIn,
  output logic      fallPulse
);

  logic meta_r;
  logic sync_r;
  logic prev_r;
  logic fall_r;

  // Synchroniser chain and one-cycle falling-edge pulse
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
      prev_r <= 1'b1;
      fall_r <= 1'b0;
    end
    else
    begin
      meta_r <= pinIn;
      sync_r <= meta_r;
      prev_r <= sync_r;
      fall_r <= prev_r & ~sync_r;
    end
  end

  assign fallPulse = fall_r;

endmodule : cet_edge_sync

/* File: design/cet_prescaler.sv */
// Free-running prescaler giving a one-cycle tick at a selectable divide ratio.
// Assumes select changes only while the timer is stopped.
`timescale 1ns/100ps
module cet_prescaler
  import cet_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Ratio select and tick out
  input  wire logic [2:0] preSel,
  output logic            preTick
);

  logic [CET_PRE_W-1:0] div_r;
  logic [CET_PRE_W-1:0] mask;
  logic                 tick_r;

  // Divide-ratio mask per select code
  always_comb
  begin
    unique case (preSel)
      CET_PRE_D2048: mask = CET_MSK_D2048;
      CET_PRE_D128:  mask = CET_MSK_D128;
      CET_PRE_D32:   mask = CET_MSK_D32;
      CET_PRE_D8:    mask = CET_MSK_D8;
      CET_PRE_D2:    mask = CET_MSK_D2;
      default:       mask = CET_MSK_D1;
    endcase
  end

  // Divider and registered tick
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      div_r  <= '0;
      tick_r <= 1'b0;
    end
    else
    begin
      div_r  <= div_r + 11'h001;
      tick_r <= (div_r & mask) == mask;
    end
  end

  assign preTick = tick_r;

endmodule : cet_prescaler

/* File: design/cet_timer.sv */
// Cascaded 16-bit timer: event counter and PWM generator behind an APB slave.
// Assumes a synchronous APB master on clk and an asynchronous count pin.
//
// Function
// - Count one per falling edge in event mode
// - Two bytes act as one 16-bit counter
// - Running event match raises irq, clears counter
// - After clear, count resumes at next edge
// - Period compare unbuffered, used immediately
// - PWM clock from prescaler or external pin
// - Duty match inverts flop, counting continues
// - Overflow inverts flop, clears counter, raises irq
// - Flop loads init bit, resets to zero
// - Output pin is inverse of flop
// - Duty double-buffered, loads at overflow or while stopped
// - Duty read returns active, not pending, value
// - Stop holds pin; init bit loads later
`timescale 1ns/100ps
module cet_timer
  import cet_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  // APB slave
  input  wire logic [CET_ADDR_W-1:0] paddr,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Timer pins
  input  wire logic                  extCountInput,
  output logic                       invertedPulseOut,
  // Interrupt request
  output logic                       cascadeMatchIrq,
  input  wire logic                  irqAck
);

  // Control and data registers
  logic [CET_BYTE_W-1:0] ctrl_r;
  logic [CET_BYTE_W-1:0] perLo_r;
  logic [CET_BYTE_W-1:0] perHi_r;
  logic [CET_BYTE_W-1:0] dutLo_r;
  logic [CET_BYTE_W-1:0] dutHi_r;
  logic [CET_CNT_W-1:0]  dutyAct_r;
  logic [CET_CNT_W-1:0]  dutyAct_nxt;
  logic [CET_CNT_W-1:0]  cnt_r;
  logic [CET_CNT_W-1:0]  cnt_nxt;
  logic                  flop_r;
  logic                  flop_nxt;
  logic                  pin_r;
  logic                  irq_r;
  logic                  irq_nxt;
  logic                  ovr_r;
  logic                  ovr_nxt;
  logic [31:0]           rdData_r;
  logic [31:0]           rdData_nxt;

  // Clock sources
  logic                  extFall;
  logic                  preTick;

  // External pin synchroniser and falling-edge detector
  // An edge reaches the counter four clocks after the pin falls
  cet_edge_sync u_sync (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .pinIn     (extCountInput),
    .fallPulse (extFall)
  );

  // Internal clock prescaler
  cet_prescaler u_pre (
    .clk     (clk),
    .sys_rst (sys_rst),
    .preSel  (ctrl_r[CET_CTRL_PRE0 +: 3]),
    .preTick (preTick)
  );

  // Control fields
  // Prescaler select is meant to change only while stopped
  wire runBit  = ctrl_r[CET_CTRL_RUN];
  wire pwmMode = ctrl_r[CET_CTRL_PWM];
  wire extSel  = ctrl_r[CET_CTRL_EXT];

  // APB address decode
  wire selCtrl  = paddr == CET_OFS_CTRL;
  wire selPerLo = paddr == CET_OFS_PER_LO;
  wire selPerHi = paddr == CET_OFS_PER_HI;
  wire selDutLo = paddr == CET_OFS_DUT_LO;
  wire selDutHi = paddr == CET_OFS_DUT_HI;
  wire selCount = paddr == CET_OFS_COUNT;
  wire selStat  = paddr == CET_OFS_STAT;
  wire mapped   = selCtrl | selPerLo | selPerHi | selDutLo | selDutHi | selCount | selStat;

  // APB phases and write strobes; writes need byte lane 0
  wire setupPh  = psel & ~penable;
  wire accessPh = psel & penable;
  wire wrLane0  = accessPh & pwrite & pstrb[0] & mapped;
  wire wrCtrl   = wrLane0 & selCtrl;
  wire wrPerLo  = wrLane0 & selPerLo;
  wire wrPerHi  = wrLane0 & selPerHi;
  wire wrDutLo  = wrLane0 & selDutLo;
  wire wrDutHi  = wrLane0 & selDutHi;
  wire wrStat   = wrLane0 & selStat;
  wire [CET_BYTE_W-1:0] wrByte = pwdata[CET_BYTE_W-1:0];

  // Bus answers: zero wait states, error on unmapped address
  assign pready  = 1'b1;
  assign pslverr = accessPh & ~mapped;
  assign prdata  = rdData_r;

  // Period compare is used straight from the written bytes
  // Changing it while running can skip a match until the count wraps
  wire [CET_CNT_W-1:0] period = {perHi_r, perLo_r};

  // Pending duty value as it stands after this cycle's writes
  // A write landing on an overflow edge is taken as it stands
  wire [CET_BYTE_W-1:0] dutLoNew  = wrDutLo ? wrByte : dutLo_r;
  wire [CET_BYTE_W-1:0] dutHiNew  = wrDutHi ? wrByte : dutHi_r;
  wire [CET_CNT_W-1:0]  dutyPend  = {dutHiNew, dutLoNew};

  // Count tick: pin edge in event mode, chosen source in PWM mode
  // The prescaler runs free, so the first tick after a start may come late
  wire pwmTick = extSel ? extFall : preTick;
  wire srcTick = pwmMode ? pwmTick : extFall;
  wire tick    = runBit & srcTick;

  // Compare and overflow events of the chained counter
  // A duty of zero hits on the overflow tick, so the two toggles cancel
  wire [CET_CNT_W-1:0] cntInc = cnt_r + CET_CNT_ONE;
  wire evMatch  = tick & ~pwmMode & (cntInc == period);
  wire overflow = tick & pwmMode & (cnt_r == CET_CNT_MAX);
  wire dutyHit  = tick & pwmMode & (cntInc == dutyAct_r);
  wire irqEvent = evMatch | overflow;

  // Flop load: only a control write made while already stopped
  // Loading on a stopping write would make the held pin level jump
  wire flopLoad = wrCtrl & ~runBit;

  // Counter next value
  always_comb
  begin
    cnt_nxt = cnt_r;
    if (irqEvent)
    begin
      cnt_nxt = CET_CNT_RST;
    end
    else if (tick)
    begin
      cnt_nxt = cntInc;
    end
  end

  // Toggle flop next value: duty match and overflow each invert it
  always_comb
  begin
    flop_nxt = flop_r ^ (dutyHit ^ overflow);
    if (flopLoad)
    begin
      flop_nxt = wrByte[CET_CTRL_FF];
    end
  end

  // Active duty: follows writes while stopped, else loads at overflow
  always_comb
  begin
    dutyAct_nxt = dutyAct_r;
    if (~runBit | overflow)
    begin
      dutyAct_nxt = dutyPend;
    end
  end

  // Interrupt request and overrun flag; a new event beats a clear
  // Overrun marks a second event while the first request still waits
  always_comb
  begin
    irq_nxt = irq_r;
    ovr_nxt = ovr_r;
    if (irqAck | (wrStat & wrByte[CET_STAT_IRQ]))
    begin
      irq_nxt = 1'b0;
    end
    if (wrStat & wrByte[CET_STAT_OVR])
    begin
      ovr_nxt = 1'b0;
    end
    if (irqEvent)
    begin
      irq_nxt = 1'b1;
      ovr_nxt = ovr_nxt | (irq_r & ~irqAck);
    end
  end

  // Read data, captured in the setup phase
  // Capturing at setup keeps prdata steady through the access cycle
  always_comb
  begin
    rdData_nxt = rdData_r;
    if (setupPh)
    begin
      rdData_nxt = '0;
      if (selCtrl)
      begin
        rdData_nxt[CET_BYTE_W-1:0] = ctrl_r;
      end
      if (selPerLo)
      begin
        rdData_nxt[CET_BYTE_W-1:0] = perLo_r;
      end
      if (selPerHi)
      begin
        rdData_nxt[CET_BYTE_W-1:0] = perHi_r;
      end
      if (selDutLo)
      begin
        rdData_nxt[CET_BYTE_W-1:0] = dutyAct_r[CET_BYTE_W-1:0];
      end
      if (selDutHi)
      begin
        rdData_nxt[CET_BYTE_W-1:0] = dutyAct_r[CET_CNT_W-1:CET_BYTE_W];
      end
      if (selCount)
      begin
        rdData_nxt[CET_CNT_W-1:0] = cnt_r;
      end
      if (selStat)
      begin
        rdData_nxt[CET_STAT_FLOP] = flop_r;
        rdData_nxt[CET_STAT_IRQ]  = irq_r;
        rdData_nxt[CET_STAT_OVR]  = ovr_r;
      end
    end
  end

  // Control register
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrl_r <= CET_CTRL_RST;
    end
    else if (wrCtrl)
    begin
      ctrl_r <= wrByte;
    end
  end

  // Period compare bytes, written directly
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      perLo_r <= CET_BYTE_RST;
      perHi_r <= CET_BYTE_RST;
    end
    else
    begin
      perLo_r <= wrPerLo ? wrByte : perLo_r;
      perHi_r <= wrPerHi ? wrByte : perHi_r;
    end
  end

  // Duty buffer bytes and active duty compare
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      dutLo_r   <= CET_BYTE_RST;
      dutHi_r   <= CET_BYTE_RST;
      dutyAct_r <= CET_CNT_RST;
    end
    else
    begin
      dutLo_r   <= dutLoNew;
      dutHi_r   <= dutHiNew;
      dutyAct_r <= dutyAct_nxt;
    end
  end

  // Chained counter
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt_r <= CET_CNT_RST;
    end
    else
    begin
      cnt_r <= cnt_nxt;
    end
  end

  // Toggle flop and inverted output pin, updated together
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      flop_r <= CET_FLOP_RST;
      pin_r  <= ~CET_FLOP_RST;
    end
    else
    begin
      flop_r <= flop_nxt;
      pin_r  <= ~flop_nxt;
    end
  end

  // Interrupt, overrun and read data registers
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      irq_r    <= 1'b0;
      ovr_r    <= 1'b0;
      rdData_r <= '0;
    end
    else
    begin
      irq_r    <= irq_nxt;
      ovr_r    <= ovr_nxt;
      rdData_r <= rdData_nxt;
    end
  end

  // Pin and interrupt outputs
  assign invertedPulseOut = pin_r;
  assign cascadeMatchIrq  = irq_r;

endmodule : cet_timer

/* File: test/cet_timer_monitor.sv */
// Port checker for the cascaded timer.
// Assumes bench traffic never sets a duty value of zero.
`timescale 1ns/100ps
module cet_timer_monitor
  import cet_pkg::*;
(
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  sys_rst,
  // APB
  input wire logic [CET_ADDR_W-1:0] paddr,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [31:0]           pwdata,
  input wire logic [3:0]            pstrb,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  // Pins and interrupt
  input wire logic                  extCountInput,
  input wire logic                  invertedPulseOut,
  input wire logic                  cascadeMatchIrq,
  input wire logic                  irqAck
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Decoded writes and reads
  logic ctrlWr, statWr, rdAcc, runR, pwmR;
  assign ctrlWr = psel && penable && pwrite && pstrb[0] && paddr == CET_OFS_CTRL;
  assign statWr = psel && penable && pwrite && pstrb[0] && paddr == CET_OFS_STAT && pwdata[1];
  assign rdAcc  = psel && penable && !pwrite;
  // Run and mode bits as software last wrote them
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      runR <= 1'b0;
      pwmR <= 1'b0;
    end
    else if (ctrlWr)
    begin
      runR <= pwdata[CET_CTRL_RUN];
      pwmR <= pwdata[CET_CTRL_PWM];
    end
  end
  property p_err; psel && penable |-> pslverr == (paddr > CET_OFS_STAT || paddr[1:0] != 2'h0); endproperty
  a_err: assert property (p_err) else $error("pslverr wrong");
  property p_errData; rdAcc && pslverr |-> prdata == 32'h0; endproperty
  a_errData: assert property (p_errData) else $error("unmapped read not zero");
  property p_flopRd; rdAcc && paddr == CET_OFS_STAT |-> prdata[0] == !$past(invertedPulseOut); endproperty
  a_flopRd: assert property (p_flopRd) else $error("flop read mismatch");
  property p_irqHold; cascadeMatchIrq && !irqAck && !statWr |=> cascadeMatchIrq; endproperty
  a_irqHold: assert property (p_irqHold) else $error("irq dropped");
  property p_rst; disable iff (1'b0) sys_rst |-> invertedPulseOut && !cascadeMatchIrq; endproperty
  a_rst: assert property (p_rst) else $error("reset value wrong");
  property p_stopHold; !runR && !ctrlWr |=> $stable(invertedPulseOut); endproperty
  a_stopHold: assert property (p_stopHold) else $error("pin moved while stopped");
  property p_evFlat; runR && !pwmR |=> $stable(invertedPulseOut); endproperty
  a_evFlat: assert property (p_evFlat) else $error("pin moved in event mode");
  property p_stopIrq; !runR && !ctrlWr |=> !$rose(cascadeMatchIrq); endproperty
  a_stopIrq: assert property (p_stopIrq) else $error("irq while stopped");
  property p_ovf; runR && pwmR && $rose(cascadeMatchIrq) |-> invertedPulseOut != $past(invertedPulseOut); endproperty
  a_ovf: assert property (p_ovf) else $error("no toggle at overflow");
endmodule : cet_timer_monitor

bind cet_timer cet_timer_monitor i_mon (.clk(clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .extCountInput(extCountInput), .invertedPulseOut(invertedPulseOut),
  .cascadeMatchIrq(cascadeMatchIrq), .irqAck(irqAck));

/* File: test/cet_pulse_src.sv */
// External pulse source driving the count pin.
// Assumes pulses() is called right after a rising clock edge.
`timescale 1ns/100ps
module cet_pulse_src
(
  // Clock and pin
  input  wire logic clk,
  output logic      pinOut
);
  // Idle high, so each pulse gives one falling edge
  initial pinOut = 1'b1;
  // Each level lasts two to five clocks
  task automatic pulses(input int n);
    repeat (n)
    begin
      pinOut <= 1'b0;
      repeat ($urandom_range(5, 2)) @(posedge clk);
      pinOut <= 1'b1;
      repeat ($urandom_range(5, 2)) @(posedge clk);
    end
  endtask : pulses
endmodule : cet_pulse_src

/* File: test/test_cet_timer.sv */
// Self-checking bench for the cascaded event/PWM timer.
// Assumes the pulse source model and the bound port checker.
`timescale 1ns/100ps
module test_cet_timer import cet_pkg::*;;
  logic                  clk = 1'b0, sys_rst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, irqAck = 1'b0;
  logic [CET_ADDR_W-1:0] paddr = '0;
  logic [31:0]           pwdata = '0, prdata;
  logic [3:0]            pstrb = '0;
  logic                  pready, pslverr, extCountInput, invertedPulseOut, cascadeMatchIrq;
  logic [31:0]           expQ[$];
  int                    n_errors = 0, comparisons = 0, n;
  // Clock
  always #12.5 clk = ~clk;
  // Design and far side
  cet_timer i_dut (.clk(clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irqAck(irqAck),
    .extCountInput(extCountInput), .invertedPulseOut(invertedPulseOut), .cascadeMatchIrq(cascadeMatchIrq));
  cet_pulse_src i_src (.clk(clk), .pinOut(extCountInput));
  task automatic stop_test;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d, input logic [3:0] s);
    @(posedge clk);
    psel    <= 1'b1;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= {24'($urandom), d};
    pstrb   <= s;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    expQ.push_back(e);
    apb(a, 1'b0, 8'h00, 4'h0);
  endtask : rd
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(a, 1'b1, d, 4'h1);
  endtask : wr
  task automatic outs(input logic p, input logic q);
    @(negedge clk);
    cmp("pin", 32'(p), 32'(invertedPulseOut));
    cmp("irq", 32'(q), 32'(cascadeMatchIrq));
    @(posedge clk);
  endtask : outs
  task automatic ack;
    irqAck <= 1'b1;
    @(posedge clk);
    irqAck <= 1'b0;
  endtask : ack
  // Each finished read takes the oldest note off the queue
  always @(posedge clk)
    if (psel && penable && pready === 1'b1 && !pwrite)
      cmp("prdata", expQ.pop_front(), prdata);
  // Watchdog
  initial
  begin
    #(90000 * 25);
    n_errors++;
    stop_test();
  end
  // Main sequence
  initial
  begin
    void'($urandom(32'h4AC21C8C));
    sys_rst <= 1'b1;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    outs(1'b1, 1'b0);
    rd(CET_OFS_STAT, 32'h0);
    rd(12'h01C, 32'h0);
    // Event counting across the byte boundary
    wr(CET_OFS_PER_LO, 8'h02);
    wr(CET_OFS_PER_HI, 8'h01);
    wr(CET_OFS_CTRL, 8'h01);
    i_src.pulses(257);
    repeat (6) @(posedge clk);
    rd(CET_OFS_COUNT, 32'h0101);
    i_src.pulses(1);
    repeat (6) @(posedge clk);
    outs(1'b1, 1'b1);
    rd(CET_OFS_COUNT, 32'h0);
    ack();
    i_src.pulses(2);
    repeat (6) @(posedge clk);
    rd(CET_OFS_COUNT, 32'h2);
    // Stopped: edges ignored, refused write, new period used at once
    wr(CET_OFS_CTRL, 8'h00);
    i_src.pulses(3);
    wr(CET_OFS_PER_LO, 8'h03);
    wr(CET_OFS_PER_HI, 8'h00);
    rd(CET_OFS_COUNT, 32'h2);
    apb(CET_OFS_CTRL, 1'b1, 8'h01, 4'h0);
    rd(CET_OFS_CTRL, 32'h0);
    wr(CET_OFS_CTRL, 8'h01);
    i_src.pulses(1);
    repeat (6) @(posedge clk);
    rd(CET_OFS_STAT, 32'h2);
    // A second match while the request waits sets the overrun flag
    i_src.pulses(3);
    repeat (6) @(posedge clk);
    rd(CET_OFS_STAT, 32'h6);
    wr(CET_OFS_STAT, 8'h06);
    // PWM on the internal clock, duty written while stopped
    wr(CET_OFS_CTRL, 8'h02);
    wr(CET_OFS_DUT_LO, 8'h10);
    wr(CET_OFS_DUT_HI, 8'h00);
    rd(CET_OFS_DUT_LO, 32'h10);
    wr(CET_OFS_CTRL, 8'h53);
    repeat (24) @(posedge clk);
    outs(1'b0, 1'b0);
    wr(CET_OFS_DUT_LO, 8'h20);
    wr(CET_OFS_DUT_HI, 8'h00);
    rd(CET_OFS_DUT_LO, 32'h10);
    n = 0;
    while (cascadeMatchIrq !== 1'b1 && n < 70000)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 70000)
      n_errors++;
    outs(1'b1, 1'b1);
    ack();
    repeat (22) @(posedge clk);
    outs(1'b1, 1'b0);
    repeat (16) @(posedge clk);
    outs(1'b0, 1'b0);
    rd(CET_OFS_DUT_LO, 32'h20);
    // Stop holds the pin; a later write loads the init bit
    wr(CET_OFS_CTRL, 8'h52);
    repeat (40) @(posedge clk);
    outs(1'b0, 1'b0);
    wr(CET_OFS_CTRL, 8'h52);
    outs(1'b1, 1'b0);
    rd(CET_OFS_STAT, 32'h0);
    wr(CET_OFS_CTRL, 8'hD2);
    outs(1'b0, 1'b0);
    // Reset while stopped clears the flop; then PWM clocked by the pin
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    outs(1'b1, 1'b0);
    wr(CET_OFS_DUT_LO, 8'h03);
    wr(CET_OFS_DUT_HI, 8'h00);
    wr(CET_OFS_CTRL, 8'h07);
    i_src.pulses(2);
    repeat (6) @(posedge clk);
    outs(1'b1, 1'b0);
    i_src.pulses(1);
    repeat (6) @(posedge clk);
    outs(1'b0, 1'b0);
    wr(CET_OFS_CTRL, 8'h06);
    rd(CET_OFS_STAT, 32'h1);
    stop_test();
  end
endmodule : test_cet_timer
